// ---- src/qmrpc_ctl.v ----
`include "qmrpc_defs.vh"

// ************************************************************
// instruction interpreter: mode, read parameters, reset
// ************************************************************
module qmrpc_ctl (
    input wire sys_clk,
    input wire rst_n,
    input wire cs_n_pin,
    input wire sclk_pin,
    input wire [3:0] io_in,
    output reg [3:0] io_out,
    output reg [3:0] io_oe,
    input wire quad_enable_bit,
    input wire [7:0] mem_data,
    output reg [23:0] mem_addr,
    output reg four_bit_command_mode,
    output reg [7:0] read_parameter_byte,
    output reg [2:0] wrap_setting_bits,
    output reg [7:0] continuous_read_bits,
    output reg [3:0] dummy_clocks,
    output reg [6:0] wrap_length,
    output reg soft_reset,
    output reg reset_busy
);
    // one-hot phase codes
    localparam [5:0] ST_OPC = 6'b00_0001;
    localparam [5:0] ST_PARAM = 6'b00_0010;
    localparam [5:0] ST_ADDR = 6'b00_0100;
    localparam [5:0] ST_DUMMY = 6'b00_1000;
    localparam [5:0] ST_DATA = 6'b01_0000;
    localparam [5:0] ST_IGN = 6'b10_0000;
    // recovery count held as a full integer, then cut to the
    // countdown width on purpose; 1500 fits in eleven bits
    localparam integer RST_CYC_FULL = `QMRPC_RST_CYC;
    localparam [10:0] RST_CYC = RST_CYC_FULL[10:0];

    // ********************************************************
    // helper functions
    // ********************************************************
    // dummy clocks from two-bit field
    function [3:0] dummy_of;
        input [1:0] f;
        begin
            dummy_of = {1'b0, f, 1'b0} + 4'h2;
        end
    endfunction

    // wrap window in bytes from two-bit field
    function [6:0] wrap_of;
        input [1:0] f;
        begin
            wrap_of = 7'h08 << f;
        end
    endfunction

    // next byte address, optionally kept inside window
    // upper bits are held; only the offset inside the window steps
    function [23:0] next_addr;
        input [23:0] a;
        input wrap;
        input [1:0] f;
        reg [23:0] m;
        reg [23:0] inc;
        begin
            m = {17'h0, wrap_of(f) - 7'h01};
            inc = a + 24'h00_0001;
            if (wrap)
                next_addr = (a & ~m) | (inc & m);
            else
                next_addr = inc;
        end
    endfunction

    // ********************************************************
    // synchronised link pins
    // ********************************************************
    wire cs_n_s; // chip select after two flops
    wire [3:0] io_s; // data lines after two flops
    wire rise; // link clock rising edge seen
    wire fall; // link clock falling edge seen

    qmrpc_pin_sync u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cs_n_pin(cs_n_pin),
        .sclk_pin(sclk_pin),
        .io_pin(io_in),
        .cs_n_s(cs_n_s),
        .io_s(io_s),
        .sclk_rise(rise),
        .sclk_fall(fall)
    );

    // ********************************************************
    // state
    // ********************************************************
    reg [5:0] state; // frame phase
    reg [2:0] cnt; // bits or nibbles in phase
    reg [7:0] opc; // opcode shift register
    reg [7:0] cmd; // latched opcode
    reg cmd_seen; // full opcode arrived in frame
    reg [7:0] pbuf; // last payload byte shifted in
    reg par_full; // payload long enough to apply
    reg [23:0] addr; // read address
    reg half; // low nibble next on output
    reg cs_d; // delayed chip select for rising edge
    reg rst_armed; // reset-enable seen last
    reg [10:0] busy_cnt; // reset recovery countdown
    reg [7:0] next_opc; // opcode with this edge's data

    // opcode shift: nibble in four-bit mode, else one bit
    always @* begin
        if (four_bit_command_mode)
            next_opc = {opc[3:0], io_s};
        else
            next_opc = {opc[6:0], io_s[0]};
    end

    // ********************************************************
    // frame engine
    // ********************************************************
    // decode happens on the fly; settings change when the frame closes, so a cut-short
    // frame changes nothing but the quad i/o read mode bits taken in its dummy phase
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_OPC;
            cnt <= 3'h0;
            opc <= 8'h00;
            cmd <= 8'h00;
            cmd_seen <= 1'b0;
            pbuf <= 8'h00;
            par_full <= 1'b0;
            addr <= 24'h00_0000;
            half <= 1'b0;
            cs_d <= 1'b1;
            rst_armed <= 1'b0;
            busy_cnt <= 11'h000;
            reset_busy <= 1'b0;
            soft_reset <= 1'b0;
            io_out <= 4'h0;
            io_oe <= 4'h0;
            mem_addr <= 24'h00_0000;
            four_bit_command_mode <= 1'b0;
            read_parameter_byte <= `QMRPC_PARAM_RST;
            wrap_setting_bits <= `QMRPC_WBITS_RST;
            continuous_read_bits <= `QMRPC_MBITS_RST;
        end else begin
            cs_d <= cs_n_s;
            soft_reset <= 1'b0;
            mem_addr <= addr;
            // reset recovery countdown
            if (busy_cnt != 11'h000)
                busy_cnt <= busy_cnt - 11'h001;
            reset_busy <= (busy_cnt > 11'h001);
            if (cs_n_s) begin
                // deselected: release lines, rearm decoder
                // a frame cut before its opcode completes leaves cmd_seen low
                state <= ST_OPC;
                cnt <= 3'h0;
                half <= 1'b0;
                io_oe <= 4'h0;
                cmd_seen <= 1'b0;
                par_full <= 1'b0;
                if (!cs_d && cmd_seen) begin
                    // frame closed: execute the instruction
                    rst_armed <= (cmd == `QMRPC_OP_RST_EN);
                    case (cmd)
                        `QMRPC_OP_RST: begin
                            if (rst_armed) begin
                                // back to power-on state
                                busy_cnt <= RST_CYC;
                                reset_busy <= 1'b1;
                                // one pulse; latch and suspend outside clear on it
                                soft_reset <= 1'b1;
                                four_bit_command_mode <= 1'b0;
                                read_parameter_byte <= `QMRPC_PARAM_RST;
                                wrap_setting_bits <= `QMRPC_WBITS_RST;
                                continuous_read_bits <= `QMRPC_MBITS_RST;
                            end
                        end
                        `QMRPC_OP_QCMD_ON: begin
                            // latch, suspend, wrap left untouched
                            if (quad_enable_bit)
                                four_bit_command_mode <= 1'b1;
                        end
                        `QMRPC_OP_QCMD_OFF: begin
                            // settings survive the mode change
                            four_bit_command_mode <= 1'b0;
                        end
                        `QMRPC_OP_SET_PARAM: begin
                            if (par_full)
                                read_parameter_byte <= pbuf;
                        end
                        `QMRPC_OP_SET_WRAP: begin
                            if (par_full) begin
                                wrap_setting_bits <= pbuf[`QMRPC_WSEL_HI:`QMRPC_WSEL_LO];
                                read_parameter_byte[`QMRPC_WRAP_HI:`QMRPC_WRAP_LO] <=
                                    pbuf[`QMRPC_WSEL_LO+1:`QMRPC_WSEL_LO];
                            end
                        end
                        default: begin
                            // reads and others only cancel reset-enable; reset-enable itself lands here and arms it
                        end
                    endcase
                end
            end else if (cs_d && busy_cnt != 11'h000) begin
                // frame opened during reset recovery: drop it
                state <= ST_IGN;
            end else if (rise) begin
                case (state)
                    ST_OPC: begin
                        opc <= next_opc;
                        cnt <= cnt + 3'h1;
                        if ((four_bit_command_mode && cnt == 3'h1) || cnt == 3'h7) begin
                            cmd <= next_opc;
                            cmd_seen <= 1'b1;
                            cnt <= 3'h0;
                            state <= ST_IGN;
                            if (four_bit_command_mode) begin
                                if (next_opc == `QMRPC_OP_SET_PARAM)
                                    state <= ST_PARAM;
                                else if (next_opc == `QMRPC_OP_FAST_RD ||
                                         next_opc == `QMRPC_OP_QIO_RD ||
                                         next_opc == `QMRPC_OP_WRAP_RD)
                                    state <= ST_ADDR;
                            end else if (next_opc == `QMRPC_OP_SET_WRAP) begin
                                // read-parameter opcode falls to ignore here
                                state <= ST_PARAM;
                            end
                        end
                    end
                    ST_PARAM: begin
                        // payload is always nibble wide
                        pbuf <= {pbuf[3:0], io_s};
                        cnt <= cnt + 3'h1;
                        if ((cmd == `QMRPC_OP_SET_PARAM && cnt == `QMRPC_PARAM_NIBS) ||
                            cnt == `QMRPC_WRAP_NIBS) begin
                            par_full <= 1'b1;
                            state <= ST_IGN;
                        end
                    end
                    ST_ADDR: begin
                        addr <= {addr[19:0], io_s};
                        cnt <= cnt + 3'h1;
                        if (cnt == `QMRPC_ADDR_NIBS) begin
                            cnt <= 3'h0;
                            state <= ST_DUMMY;
                        end
                    end
                    ST_DUMMY: begin
                        // quad i/o read carries mode bits first
                        if (cmd == `QMRPC_OP_QIO_RD && cnt < 3'h2)
                            continuous_read_bits <= {continuous_read_bits[3:0], io_s};
                        cnt <= cnt + 3'h1;
                        // last dummy rise moves to data, so the first nibble leaves on its fall
                        if ({1'b0, cnt} == dummy_clocks - 4'h1) begin
                            cnt <= 3'h0;
                            state <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        // host clocks data out; nothing to take in
                        // a partial last byte is simply dropped at deselect
                    end
                    ST_IGN: begin
                        // rest of frame ignored
                    end
                    default: begin
                        state <= ST_IGN;
                    end
                endcase
            end else if (fall && state == ST_DATA) begin
                // high nibble first, then low, then next byte
                io_oe <= 4'hF;
                io_out <= half ? mem_data[3:0] : mem_data[7:4];
                half <= ~half;
                if (half)
                    addr <= next_addr(addr, cmd == `QMRPC_OP_WRAP_RD,
                        read_parameter_byte[`QMRPC_WRAP_HI:`QMRPC_WRAP_LO]);
            end
        end
    end

    // ********************************************************
    // read settings seen by the read path
    // ********************************************************
    // fixed count outside four-bit mode; programmed one inside.
    // one cycle behind the parameter byte, far below a link clock
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dummy_clocks <= 4'h2;
            wrap_length <= 7'h08;
        end else begin
            if (four_bit_command_mode)
                dummy_clocks <= dummy_of(read_parameter_byte[`QMRPC_DUMMY_HI:`QMRPC_DUMMY_LO]);
            else
                dummy_clocks <= `QMRPC_SER_DUMMY;
            wrap_length <= wrap_of(read_parameter_byte[`QMRPC_WRAP_HI:`QMRPC_WRAP_LO]);
        end
    end
endmodule // qmrpc_ctl

// ---- common/qmrpc_defs.vh ----
// How it works
// - four-bit mode accepts read-parameter instruction
// - serial mode rejects read-parameter, settings kept
// - serial reads fixed dummy; programmed only four-bit
// - serial wrap length from wrap-select, kept
// - after reset: wrap 8 bytes, dummy 2
// - dummy field 00/01/10/11 gives 2/4/6/8
// - wrap field 00/01/10/11 gives 8/16/32/64
// - wrapped read wraps inside aligned window
// - one mode only; enable instruction enters
// - power-up starts in serial mode
// - enter four-bit mode only with quad enable
// - entering keeps latch, suspend, wrap length
// - disable instruction returns to serial mode
// - leaving keeps latch, suspend, wrap length
// - software reset clears volatile settings, aborts
// - reset needs reset-enable directly before reset
// - any other instruction cancels reset-enable
// - ignore all instructions for 30us after reset
`ifndef QMRPC_DEFS_VH
`define QMRPC_DEFS_VH

// ************************************************************
// instruction codes
// ************************************************************
`define QMRPC_OP_SET_PARAM 8'hC0
`define QMRPC_OP_FAST_RD 8'h0B
`define QMRPC_OP_QIO_RD 8'hEB
`define QMRPC_OP_WRAP_RD 8'h0C
`define QMRPC_OP_SET_WRAP 8'h77
`define QMRPC_OP_QCMD_ON 8'h38
`define QMRPC_OP_QCMD_OFF 8'hFF
`define QMRPC_OP_RST_EN 8'h66
`define QMRPC_OP_RST 8'h99

// ************************************************************
// field positions and reset values
// ************************************************************
`define QMRPC_DUMMY_HI 5
`define QMRPC_DUMMY_LO 4
`define QMRPC_WRAP_HI 1
`define QMRPC_WRAP_LO 0
`define QMRPC_WSEL_HI 6
`define QMRPC_WSEL_LO 4
`define QMRPC_PARAM_RST 8'h00
`define QMRPC_WBITS_RST 3'h0
`define QMRPC_MBITS_RST 8'h00
`define QMRPC_SER_DUMMY 4'h8

// ************************************************************
// last count of each phase in link clocks (one less than its length) and timing
// ************************************************************
`define QMRPC_ADDR_NIBS 3'h5
`define QMRPC_PARAM_NIBS 3'h1
`define QMRPC_WRAP_NIBS 3'h7
`define QMRPC_CLK_MHZ 50
`define QMRPC_T_RST_NS 30000
`define QMRPC_RST_CYC (`QMRPC_T_RST_NS * `QMRPC_CLK_MHZ / 1000)

`endif

// ---- src/qmrpc_pin_sync.v ----
// ************************************************************
// pin synchroniser and link clock edge finder
// ************************************************************
module qmrpc_pin_sync (
    input wire sys_clk,
    input wire rst_n,
    input wire cs_n_pin,
    input wire sclk_pin,
    input wire [3:0] io_pin,
    output reg cs_n_s,
    output reg [3:0] io_s,
    output wire sclk_rise,
    output wire sclk_fall
);
    reg cs_n_m; // first stage, read only by second
    reg sclk_m; // first stage
    reg [3:0] io_m; // first stage
    reg sclk_s; // second stage
    reg sclk_d; // delayed copy for edge finding

    // two flops per pin, three on the link clock; idle levels under reset
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_n_m <= 1'b1;
            cs_n_s <= 1'b1;
            sclk_m <= 1'b0;
            sclk_s <= 1'b0;
            sclk_d <= 1'b0;
            io_m <= 4'h0;
            io_s <= 4'h0;
        end else begin
            cs_n_m <= cs_n_pin;
            cs_n_s <= cs_n_m;
            sclk_m <= sclk_pin;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
            io_m <= io_pin;
            io_s <= io_m;
        end
    end

    // edges seen only on synchronised copies
    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;
endmodule // qmrpc_pin_sync

// ---- test/qmrpc_checker.sv ----
// ************************************************************
// port checker for the instruction interpreter
// ************************************************************
module qmrpc_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cs_n_pin,
    input wire logic quad_enable_bit,
    input wire logic [3:0] io_oe,
    input wire logic four_bit_command_mode,
    input wire logic [7:0] read_parameter_byte,
    input wire logic [2:0] wrap_setting_bits,
    input wire logic [7:0] continuous_read_bits,
    input wire logic [3:0] dummy_clocks,
    input wire logic [6:0] wrap_length,
    input wire logic soft_reset,
    input wire logic reset_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] busy_cnt; // cycles spent in recovery so far
    // counter instead of a long repetition, which the tools would unroll
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt <= 12'h000;
        end else begin
            busy_cnt <= reset_busy ? busy_cnt + 12'h001 : 12'h000;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ************************************************************
    // assertions
    // ************************************************************
    a_reset_dflt: assert property ($rose(rst_n) |-> !four_bit_command_mode && dummy_clocks == 4'h2
        && wrap_length == 7'h08) else $error("wrong state after power-up");
    a_soft_clear: assert property (soft_reset |=> reset_busy && !four_bit_command_mode
        && read_parameter_byte == 8'h00 && wrap_setting_bits == 3'h0 && continuous_read_bits == 8'h00)
        else $error("software reset left settings behind");
    a_soft_pulse: assert property (soft_reset |=> !soft_reset) else $error("reset pulse too long");
    // 1500 cycles is 30 us at 50 MHz
    a_busy_len: assert property ($fell(reset_busy) |-> busy_cnt == 12'h5DC)
        else $error("recovery length wrong");
    a_busy_frozen: assert property (reset_busy && !soft_reset |=> $stable(four_bit_command_mode)
        && $stable(read_parameter_byte) && $stable(wrap_setting_bits)) else $error("frame acted during recovery");
    a_dummy_map: assert property (four_bit_command_mode && $past(four_bit_command_mode, 2)
        && read_parameter_byte == $past(read_parameter_byte, 2)
        |-> dummy_clocks == {1'b0, read_parameter_byte[5:4], 1'b0} + 4'h2) else $error("dummy count mismatch");
    a_wrap_map: assert property (read_parameter_byte == $past(read_parameter_byte, 2)
        |-> wrap_length == (7'h08 << read_parameter_byte[1:0])) else $error("wrap length mismatch");
    // a software reset may clear the byte one edge later; that is allowed
    a_serial_reject: assert property (!four_bit_command_mode
        |=> soft_reset || $stable(read_parameter_byte[7:2])) else $error("parameter changed in serial mode");
    a_entry_keep: assert property ($rose(four_bit_command_mode) |-> $past(quad_enable_bit)
        && $stable(wrap_setting_bits) && $stable(read_parameter_byte)) else $error("bad mode entry");
    a_exit_keep: assert property ($fell(four_bit_command_mode) && !soft_reset
        |-> $stable(wrap_setting_bits) && $stable(read_parameter_byte)) else $error("bad mode exit");
    a_oe_idle: assert property (cs_n_pin [*5] |-> io_oe == 4'h0) else $error("lines driven while idle");
    c_soft: cover property (soft_reset);
    c_entry: cover property ($rose(four_bit_command_mode));
    c_recover: cover property ($fell(reset_busy));
endmodule // qmrpc_checker

// ---- test/qmrpc_host.sv ----
// ************************************************************
// behavioural host controller: chip select, link clock, lines
// ************************************************************
module qmrpc_host (
    input wire logic sys_clk,
    input wire logic [3:0] io_in,
    output logic cs_n,
    output logic sclk,
    output logic [3:0] io_host
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] got; // nibble taken late in the high phase
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io_host = 4'h0;
        got = 4'h0;
    end
    // one 160 ns link clock; sampled late so slow device answers settle
    task automatic clk(input logic [3:0] v);
        io_host = v;
        repeat (4) @(negedge sys_clk);
        sclk = 1'b1;
        repeat (4) @(negedge sys_clk);
        got = io_in;
        sclk = 1'b0;
    endtask
    task automatic nibs(input int n, input logic [63:0] d);
        for (int i = n - 1; i >= 0; i--) begin
            clk(d[4*i +: 4]);
        end
    endtask
    task automatic ser(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            clk({3'b000, b[i]});
        end
    endtask
    task automatic open_f();
        cs_n = 1'b0;
    endtask
    // link clock stands still; released lines show the inverse
    task automatic close_f();
        cs_n = 1'b1;
        io_host = ~io_host;
        repeat (10) @(negedge sys_clk);
    endtask
endmodule // qmrpc_host

// ---- test/tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic quad_enable_bit = 1'b0;
    logic cs_n_pin, sclk_pin, four_bit_command_mode, soft_reset, reset_busy;
    logic [3:0] io_host, io_out, io_oe, io_in, dummy_clocks;
    logic [23:0] mem_addr;
    logic [7:0] mem_data, read_parameter_byte, continuous_read_bits, hi_lo;
    logic [2:0] wrap_setting_bits;
    logic [6:0] wrap_length;
    int fails = 0;
    int samples_checked = 0;
    int resets = 0;
    int cyc = 0;
    always #10 sys_clk = ~sys_clk;
    // wire level from the device enable alone; array data is a simple address pattern
    assign io_in = (io_oe & io_out) | (~io_oe & io_host);
    assign mem_data = mem_addr[7:0] ^ 8'h5A;
    qmrpc_ctl i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .quad_enable_bit(quad_enable_bit),
        .mem_data(mem_data), .mem_addr(mem_addr), .four_bit_command_mode(four_bit_command_mode),
        .read_parameter_byte(read_parameter_byte), .wrap_setting_bits(wrap_setting_bits),
        .continuous_read_bits(continuous_read_bits), .dummy_clocks(dummy_clocks),
        .wrap_length(wrap_length), .soft_reset(soft_reset), .reset_busy(reset_busy));
    qmrpc_host i_host (.sys_clk(sys_clk), .io_in(io_in), .cs_n(cs_n_pin), .sclk(sclk_pin), .io_host(io_host));
    // reset pulses and hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (soft_reset === 1'b1) begin
            resets++;
        end
        if (cyc == 12000) begin
            fails++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, m, g, e);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // one whole frame: opcode then n payload nibbles
    task automatic fr(input logic [7:0] op, input logic four, input int n, input logic [63:0] d);
        i_host.open_f();
        if (four) begin
            i_host.nibs(2, {56'h0, op});
        end else begin
            i_host.ser(op);
        end
        i_host.nibs(n, d);
        i_host.close_f();
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk) rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk(four_bit_command_mode, 32'h0, "power-up mode");
        chk(dummy_clocks, 32'h8, "power-up serial dummy");
        chk(read_parameter_byte, 32'h0, "power-up parameter");
        chk(wrap_length, 32'h8, "power-up wrap");
        fr(8'hC0, 1'b0, 2, 64'h33);
        chk(read_parameter_byte, 32'h0, "serial parameter taken");
        fr(8'h77, 1'b0, 8, 64'h20);
        chk(wrap_setting_bits, 32'h2, "wrap bits");
        chk(wrap_length, 32'h20, "serial wrap length");
        $display("test serial done");
        fr(8'h66, 1'b0, 0, 64'h0);
        fr(8'h05, 1'b0, 0, 64'h0);
        fr(8'h99, 1'b0, 0, 64'h0);
        chk(reset_busy, 32'h0, "cancelled reset ran");
        chk(wrap_setting_bits, 32'h2, "cancelled reset cleared");
        fr(8'h38, 1'b0, 0, 64'h0);
        chk(four_bit_command_mode, 32'h0, "entry without quad enable");
        quad_enable_bit = 1'b1;
        fr(8'h38, 1'b0, 0, 64'h0);
        chk(four_bit_command_mode, 32'h1, "entry");
        chk(wrap_length, 32'h20, "entry wrap kept");
        chk(dummy_clocks, 32'h2, "entry dummy");
        for (int k = 0; k < 4; k++) begin
            fr(8'hC0, 1'b1, 2, {58'h0, 2'(k), 2'b00, 2'(k)});
            chk(dummy_clocks, 2 + 2 * k, "dummy code");
            chk(wrap_length, 8 << k, "wrap code");
        end
        $display("test parameters done");
        fr(8'hC0, 1'b1, 2, 64'h0);
        i_host.open_f();
        i_host.nibs(8, 64'h0C00_0106);
        repeat (2) i_host.clk(~io_host);
        for (int b = 0; b < 4; b++) begin
            i_host.clk(~io_host);
            hi_lo[7:4] = i_host.got;
            i_host.clk(~io_host);
            hi_lo[3:0] = i_host.got;
            chk(hi_lo, {5'h0, 3'(b + 6)} ^ 8'h5A, "wrapped byte");
        end
        i_host.close_f();
        $display("test wrapped read done");
        i_host.open_f();
        i_host.nibs(8, 64'h0B00_0107);
        repeat (2) i_host.clk(~io_host);
        for (int b = 0; b < 2; b++) begin
            i_host.clk(~io_host);
            hi_lo[7:4] = i_host.got;
            i_host.clk(~io_host);
            hi_lo[3:0] = i_host.got;
            chk(hi_lo, 8'(7 + b) ^ 8'h5A, "fast byte");
        end
        i_host.close_f();
        i_host.open_f();
        i_host.nibs(10, 64'hEB_0000_10A5);
        i_host.clk(~io_host);
        hi_lo[7:4] = i_host.got;
        i_host.clk(~io_host);
        hi_lo[3:0] = i_host.got;
        i_host.close_f();
        chk(hi_lo, 8'h10 ^ 8'h5A, "quad i/o byte");
        chk(continuous_read_bits, 32'hA5, "mode bits");
        $display("test fast reads done");
        fr(8'hFF, 1'b1, 0, 64'h0);
        chk(four_bit_command_mode, 32'h0, "exit");
        chk(wrap_setting_bits, 32'h2, "exit wrap kept");
        fr(8'h38, 1'b0, 0, 64'h0);
        fr(8'h66, 1'b1, 0, 64'h0);
        fr(8'h99, 1'b1, 0, 64'h0);
        chk(resets, 32'h1, "reset pulses");
        chk(reset_busy, 32'h1, "recovery");
        chk({four_bit_command_mode, read_parameter_byte, wrap_setting_bits}, 32'h0, "volatile cleared");
        fr(8'h38, 1'b0, 0, 64'h0);
        chk(four_bit_command_mode, 32'h0, "frame during recovery");
        for (int i = 0; i < 2000 && reset_busy !== 1'b0; i++) begin
            @(negedge sys_clk);
        end
        repeat (4) @(negedge sys_clk);
        chk(reset_busy, 32'h0, "recovery end");
        fr(8'h38, 1'b0, 0, 64'h0);
        chk(dummy_clocks, 32'h2, "reset dummy");
        chk(wrap_length, 32'h8, "reset wrap");
        $display("test software reset done");
        test_done();
    end
endmodule // tb

bind qmrpc_ctl qmrpc_checker i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n_pin(cs_n_pin),
    .quad_enable_bit(quad_enable_bit), .io_oe(io_oe), .four_bit_command_mode(four_bit_command_mode),
    .read_parameter_byte(read_parameter_byte), .wrap_setting_bits(wrap_setting_bits),
    .continuous_read_bits(continuous_read_bits), .dummy_clocks(dummy_clocks),
    .wrap_length(wrap_length), .soft_reset(soft_reset), .reset_busy(reset_busy));
